// file: sfcfe_pkg.sv
/*
 * sfcfe_pkg: opcodes, identity values, address map and byte counts for
 * the serial flash command front end. Assumes nothing of its surroundings.
 */
package sfcfe_pkg;
    // opcodes
    localparam logic [7:0] OP_LATCH_SET = 8'h06;
    localparam logic [7:0] OP_LATCH_CLEAR = 8'h04;
    localparam logic [7:0] OP_IDENT_READ = 8'h9F;
    localparam logic [7:0] OP_STATUS_FETCH = 8'h05;
    localparam logic [7:0] OP_STATUS_STORE = 8'h01;
    localparam logic [7:0] OP_READ = 8'h03;
    localparam logic [7:0] OP_FAST_READ = 8'h0B;
    localparam logic [7:0] OP_SECTOR_WIPE = 8'h20;
    localparam logic [7:0] OP_BLOCK_WIPE_A = 8'h52;
    localparam logic [7:0] OP_BLOCK_WIPE_B = 8'hD8;
    localparam logic [7:0] OP_CHIP_WIPE_A = 8'h60;
    localparam logic [7:0] OP_CHIP_WIPE_B = 8'hC7;
    localparam logic [7:0] OP_PAGE_WRITE = 8'h02;
    localparam logic [7:0] OP_SLEEP_ENTER = 8'hB9;
    localparam logic [7:0] OP_SLEEP_EXIT = 8'hAB;
    localparam logic [7:0] OP_MAKER_PART = 8'h90;
    // identity values: arbitrary neutral values
    localparam logic [7:0] MAKER_CODE = 8'h5A;
    localparam logic [7:0] PART_TYPE = 8'h11;
    localparam logic [7:0] PART_CODE = 8'h22;
    localparam logic [7:0] SIGNATURE = 8'h33;
    // address map
    localparam logic [23:0] ADDR_LAST = 24'h1F_FFFF;
    localparam int SECTOR_LSB = 12;
    localparam int BLOCK_LSB = 16;
    // frame byte counts (opcode is byte 1) and maker-first selector value
    localparam logic [15:0] BYTE_ADDR_END = 16'h0004;
    localparam logic [15:0] BYTE_FAST_DUMMY = 16'h0005;
    localparam logic [7:0] SEL_MAKER_FIRST = 8'h00;
    // actions
    typedef enum logic [3:0] {
        SF_ACT_NONE, SF_ACT_LATCH_SET, SF_ACT_LATCH_CLEAR, SF_ACT_STATUS_STORE,
        SF_ACT_SECTOR_WIPE, SF_ACT_BLOCK_WIPE, SF_ACT_CHIP_WIPE, SF_ACT_PAGE_WRITE,
        SF_ACT_SLEEP_ENTER, SF_ACT_SLEEP_EXIT
    } sfcfe_act_t;
endpackage : sfcfe_pkg

// file: sfcfe_sync.sv
/*
 * sfcfe_sync: two flip-flop synchroniser for one pin level.
 * Assumes the pin is asynchronous to clk.
 */
`timescale 1ns/1ps
module sfcfe_sync #(
    parameter logic RST_VAL = 1'b0
) (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // level
    input wire logic pin,
    output logic level
);
    logic meta_q;
    logic meta_d;
    logic level_q;
    logic level_d;

    always_comb begin
        meta_d = pin;
        level_d = meta_q;
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            meta_q <= RST_VAL;
            level_q <= RST_VAL;
        end else begin
            meta_q <= meta_d;
            level_q <= level_d;
        end
    end

    assign level = level_q;
endmodule : sfcfe_sync

// file: sfcfe_top.sv
/*
 * sfcfe_top: serial command front end of a serial flash. Samples the
 * host's pins on clk, decodes commands, drives the data output and
 * issues one-cycle action pulses to the array side.
 * Assumes clk runs much faster than the serial clock (at least 4x).
 */
`timescale 1ns/1ps
// How it works
// - pause stops only serial shifting; array busy work is untouched
// - pause begins on pause-low while select low, once serial clock is low
// - pause ends on pause-high, deferred until serial clock is low
// - while paused, output released and data and clock ignored
// - select rising during pause abandons the command
// - 06h sets write latch, 04h clears it; single byte only
// - 20h sector wipe, 52h/D8h block wipe, 60h/C7h chip wipe
// - 02h with address and data starts page write
// - B9h sleeps, ABh alone wakes, ABh plus dummies shifts signature without waking
// - 90h with selector 00h gives maker first, 01h part first
// - sample input on rising edge, change output on falling edge
// - write-type commands run only if select rises on byte boundary
// - unknown opcode: standby with output released until next frame
// - write latch clears on completion of write-type commands
module sfcfe_top
    import sfcfe_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // serial pins from host
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic mosi,
    input wire logic hold_n,
    // serial data out
    output logic miso_o,
    output logic miso_oe,
    // array side
    input wire logic array_busy,
    input wire logic [7:0] array_rdata,
    output logic [3:0] act_o,
    output logic act_stb,
    output logic [23:0] act_addr,
    output logic [7:0] act_data,
    output logic act_data_stb,
    output logic [7:0] status_o,
    output logic write_permit_latch,
    output logic sleep_o
);
    logic cs_n_s, sclk_s, mosi_s, hold_n_s;
    sfcfe_sync #(.RST_VAL(1'b1)) u_cs (.clk(clk), .nrst(nrst), .pin(cs_n), .level(cs_n_s));
    sfcfe_sync #(.RST_VAL(1'b0)) u_ck (.clk(clk), .nrst(nrst), .pin(sclk), .level(sclk_s));
    sfcfe_sync #(.RST_VAL(1'b0)) u_si (.clk(clk), .nrst(nrst), .pin(mosi), .level(mosi_s));
    sfcfe_sync #(.RST_VAL(1'b1)) u_ho (.clk(clk), .nrst(nrst), .pin(hold_n), .level(hold_n_s));

    logic sclk_q, sclk_d, cs_q, cs_d, pause_q, pause_d, standby_q, standby_d;
    logic [2:0] bit_q, bit_d;
    logic [15:0] byte_q, byte_d;
    logic [7:0] sh_q, sh_d, op_q, op_d, out_q, out_d, sel_q, sel_d;
    logic [23:0] addr_q, addr_d;
    logic wel_q, wel_d, sleep_q, sleep_d, miso_q, miso_d, oe_q, oe_d;
    logic en_q, en_d;
    logic [7:0] stat_q, stat_d;
    logic [3:0] act_q, act_d;
    logic act_stb_q, act_stb_d, dstb_q, dstb_d;
    logic [7:0] dat_q, dat_d;
    logic [23:0] aout_q, aout_d;
    logic [7:0] byte_in;
    logic rise, fall, cs_rise, cs_fall, live, known;
    sfcfe_act_t act;

    always_comb begin
        rise = sclk_s && !sclk_q;
        fall = !sclk_s && sclk_q;
        cs_rise = cs_n_s && !cs_q;
        cs_fall = !cs_n_s && cs_q;
        live = !cs_n_s && !pause_q && !standby_q;
        byte_in = {sh_q[6:0], mosi_s};
        unique case (op_q)
            OP_LATCH_SET, OP_LATCH_CLEAR, OP_IDENT_READ, OP_STATUS_FETCH, OP_STATUS_STORE,
            OP_READ, OP_FAST_READ, OP_SECTOR_WIPE, OP_BLOCK_WIPE_A, OP_BLOCK_WIPE_B,
            OP_CHIP_WIPE_A, OP_CHIP_WIPE_B, OP_PAGE_WRITE, OP_SLEEP_ENTER, OP_SLEEP_EXIT,
            OP_MAKER_PART: known = 1'b1;
            default: known = 1'b0;
        endcase
        // action decided at select rise on a byte boundary: byte count exact, except page write which takes any count past the address
        act = SF_ACT_NONE;
        if (bit_q == 3'd0) begin
            unique case (op_q)
                OP_LATCH_SET: if (byte_q == 16'd1) act = SF_ACT_LATCH_SET;
                OP_LATCH_CLEAR: if (byte_q == 16'd1) act = SF_ACT_LATCH_CLEAR;
                OP_STATUS_STORE: if (byte_q == 16'd2 && wel_q) act = SF_ACT_STATUS_STORE;
                OP_SECTOR_WIPE: if (byte_q == BYTE_ADDR_END && wel_q) act = SF_ACT_SECTOR_WIPE;
                OP_BLOCK_WIPE_A, OP_BLOCK_WIPE_B:
                    if (byte_q == BYTE_ADDR_END && wel_q) act = SF_ACT_BLOCK_WIPE;
                OP_CHIP_WIPE_A, OP_CHIP_WIPE_B:
                    if (byte_q == 16'd1 && wel_q) act = SF_ACT_CHIP_WIPE;
                OP_PAGE_WRITE:
                    if (byte_q > BYTE_ADDR_END && wel_q) act = SF_ACT_PAGE_WRITE;
                OP_SLEEP_ENTER: if (byte_q == 16'd1) act = SF_ACT_SLEEP_ENTER;
                OP_SLEEP_EXIT: if (byte_q == 16'd1) act = SF_ACT_SLEEP_EXIT;
                default: act = SF_ACT_NONE;
            endcase
        end
    end

    always_comb begin
        sclk_d = sclk_s;
        cs_d = cs_n_s;
        pause_d = pause_q;
        standby_d = standby_q;
        bit_d = bit_q;
        byte_d = byte_q;
        sh_d = sh_q;
        op_d = op_q;
        sel_d = sel_q;
        addr_d = addr_q;
        out_d = out_q;
        wel_d = wel_q;
        sleep_d = sleep_q;
        stat_d = stat_q;
        miso_d = miso_q;
        oe_d = oe_q;
        act_d = act_q;
        act_stb_d = 1'b0;
        dstb_d = 1'b0;
        dat_d = dat_q;
        aout_d = aout_q;
        stat_d[0] = array_busy;
        stat_d[1] = wel_q;
        // pause clears while select is high, else only moves while serial clock is low
        if (cs_n_s) begin
            pause_d = 1'b0;
        end else if (!sclk_s) begin
            pause_d = !hold_n_s;
        end
        if (cs_fall) begin
            bit_d = 3'd0;
            byte_d = 16'd0;
            standby_d = 1'b0;
            op_d = 8'h00;
        end
        if (cs_rise) begin
            oe_d = 1'b0;
            // select rise while paused abandons the frame
            if (!pause_q && !standby_q && act != SF_ACT_NONE) begin
                act_d = act;
                act_stb_d = 1'b1;
                aout_d = addr_q & ADDR_LAST;
                unique case (act)
                    SF_ACT_LATCH_SET: wel_d = 1'b1;
                    SF_ACT_SLEEP_ENTER: sleep_d = 1'b1;
                    SF_ACT_SLEEP_EXIT: sleep_d = 1'b0;
                    SF_ACT_STATUS_STORE: begin
                        wel_d = 1'b0;
                        stat_d[7:2] = sel_q[7:2];
                    end
                    default: wel_d = 1'b0;
                endcase
            end
            bit_d = 3'd0;
            byte_d = 16'd0;
        end else if (live && rise) begin
            sh_d = byte_in;
            bit_d = bit_q + 3'd1;
            if (bit_q == 3'd7) begin
                byte_d = byte_q + 16'd1;
                if (byte_q == 16'd0) begin
                    op_d = byte_in;
                end else if (byte_q < BYTE_ADDR_END) begin
                    addr_d = {addr_q[15:0], byte_in};
                end else if (op_q == OP_PAGE_WRITE) begin
                    dat_d = byte_in;
                    dstb_d = 1'b1;
                end
                if (byte_q == 16'd1 || byte_q == BYTE_ADDR_END - 16'd1) begin
                    sel_d = byte_in;
                end
            end
        end else if (live && fall) begin
            if (byte_q == 16'd1 && bit_q == 3'd0 && !known) begin
                standby_d = 1'b1;
                oe_d = 1'b0;
            end else if (bit_q == 3'd0) begin
                oe_d = 1'b1;
                unique case (op_q)
                    OP_IDENT_READ: out_d = (byte_q == 16'd1) ? MAKER_CODE :
                        ((byte_q == 16'd2) ? PART_TYPE : PART_CODE);
                    OP_STATUS_FETCH: out_d = stat_q;
                    OP_READ: out_d = (byte_q >= BYTE_ADDR_END) ? array_rdata : 8'h00;
                    OP_FAST_READ: out_d = (byte_q >= BYTE_FAST_DUMMY) ? array_rdata : 8'h00;
                    OP_SLEEP_EXIT: out_d = (byte_q >= BYTE_ADDR_END) ? SIGNATURE : 8'h00;
                    OP_MAKER_PART: out_d = ((byte_q[0] == 1'b0) == (sel_q == SEL_MAKER_FIRST))
                        ? MAKER_CODE : PART_CODE;
                    default: begin
                        out_d = 8'h00;
                        oe_d = 1'b0;
                    end
                endcase
                // only drive in the data phase of each output command
                if ((op_q == OP_READ || op_q == OP_SLEEP_EXIT || op_q == OP_MAKER_PART)
                        && byte_q < BYTE_ADDR_END) oe_d = 1'b0;
                if (op_q == OP_FAST_READ && byte_q < BYTE_FAST_DUMMY) oe_d = 1'b0;
                if (byte_q == 16'd0) oe_d = 1'b0;
                miso_d = out_d[7];
                out_d = {out_d[6:0], 1'b0};
            end else begin
                miso_d = out_q[7];
                out_d = {out_q[6:0], 1'b0};
            end
        end
        if (standby_q || cs_n_s) oe_d = 1'b0;
        // drive intent survives a pause, so output resumes mid-byte
        en_d = oe_d && !pause_q;
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            sclk_q <= 1'b0;
            cs_q <= 1'b1;
            pause_q <= 1'b0;
            standby_q <= 1'b0;
            bit_q <= 3'd0;
            byte_q <= 16'd0;
            sh_q <= 8'h00;
            op_q <= 8'h00;
            sel_q <= 8'h00;
            addr_q <= 24'h00_0000;
            out_q <= 8'h00;
            wel_q <= 1'b0;
            sleep_q <= 1'b0;
            stat_q <= 8'h00;
            miso_q <= 1'b0;
            oe_q <= 1'b0;
            en_q <= 1'b0;
            act_q <= 4'h0;
            act_stb_q <= 1'b0;
            dstb_q <= 1'b0;
            dat_q <= 8'h00;
            aout_q <= 24'h00_0000;
        end else begin
            sclk_q <= sclk_d;
            cs_q <= cs_d;
            pause_q <= pause_d;
            standby_q <= standby_d;
            bit_q <= bit_d;
            byte_q <= byte_d;
            sh_q <= sh_d;
            op_q <= op_d;
            sel_q <= sel_d;
            addr_q <= addr_d;
            out_q <= out_d;
            wel_q <= wel_d;
            sleep_q <= sleep_d;
            stat_q <= stat_d;
            miso_q <= miso_d;
            oe_q <= oe_d;
            en_q <= en_d;
            act_q <= act_d;
            act_stb_q <= act_stb_d;
            dstb_q <= dstb_d;
            dat_q <= dat_d;
            aout_q <= aout_d;
        end
    end

    assign miso_o = miso_q;
    assign miso_oe = en_q;
    assign act_o = act_q;
    assign act_stb = act_stb_q;
    assign act_addr = aout_q;
    assign act_data = dat_q;
    assign act_data_stb = dstb_q;
    assign status_o = stat_q;
    assign write_permit_latch = wel_q;
    assign sleep_o = sleep_q;

    a_pause_oe: assert property (@(posedge clk) disable iff (!nrst)
        pause_q |=> !miso_oe) else $error("output driven while paused");
    a_pause_start: assert property (@(posedge clk) disable iff (!nrst)
        (!cs_n_s && !sclk_s && !hold_n_s) |=> pause_q) else $error("pause not begun");
    a_pause_hold: assert property (@(posedge clk) disable iff (!nrst)
        (pause_q && sclk_s && !cs_n_s) |=> pause_q) else $error("pause ended on high clock");
    a_pause_count: assert property (@(posedge clk) disable iff (!nrst)
        (pause_q && !cs_rise && !cs_fall) |=> $stable(bit_q)) else $error("bits moved in pause");
    a_abandon: assert property (@(posedge clk) disable iff (!nrst)
        (cs_rise && pause_q) |=> !act_stb) else $error("paused command ran");
    a_latch_set: assert property (@(posedge clk) disable iff (!nrst)
        (act_stb && act_o == 4'(SF_ACT_LATCH_SET)) |-> wel_q) else $error("latch not set");
    a_latch_clr: assert property (@(posedge clk) disable iff (!nrst)
        (act_stb && act_o != 4'(SF_ACT_LATCH_SET) && act_o != 4'(SF_ACT_SLEEP_ENTER)
        && act_o != 4'(SF_ACT_SLEEP_EXIT)) |-> !wel_q) else $error("latch not cleared");
    a_boundary: assert property (@(posedge clk) disable iff (!nrst)
        (cs_rise && bit_q != 3'd0) |=> !act_stb) else $error("partial byte ran");
    a_standby: assert property (@(posedge clk) disable iff (!nrst)
        standby_q |=> !miso_oe) else $error("standby drives output");
    a_addr_span: assert property (@(posedge clk) disable iff (!nrst)
        act_stb |-> act_addr <= ADDR_LAST) else $error("address beyond span");
endmodule : sfcfe_top

// file: sfcfe_host.sv
/*
 * sfcfe_host: mode 0 spi host model driving the front end pins.
 * Assumes clk at 100 MHz; the serial clock runs only inside frames.
 */
`timescale 1ns/1ps
module sfcfe_host (
    // clock
    input wire logic clk,
    // pins to device
    output logic cs_n,
    output logic sclk,
    output logic mosi,
    output logic hold_n,
    // pins from device
    input wire logic miso_o,
    input wire logic miso_oe
);
    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
        mosi = 1'b0;
        hold_n = 1'b1;
    end

    // msb first, 90 ns serial period; reads just before each fall
    task automatic bits(input logic [7:0] tx, input int n, output logic [7:0] rx,
        output logic oe);
        rx = 8'h00;
        oe = 1'b0;
        for (int i = 0; i < n; i++) begin
            @(posedge clk) mosi <= tx[7-i];
            repeat (4) @(posedge clk);
            sclk <= 1'b1;
            repeat (3) @(posedge clk);
            @(negedge clk);
            rx = {rx[6:0], miso_o};
            oe = oe | miso_oe;
            @(posedge clk) sclk <= 1'b0;
        end
    endtask : bits

    // select change; data line scrambled so no stale bit lingers
    task automatic sel(input logic lvl);
        repeat (4) @(posedge clk);
        cs_n <= lvl;
        mosi <= ~mosi;
        repeat (12) @(posedge clk);
    endtask : sel

    // always called with sclk low
    task automatic pause(input logic lvl);
        @(posedge clk) hold_n <= lvl;
        repeat (8) @(posedge clk);
    endtask : pause
endmodule : sfcfe_host

// file: tb_sfcfe_top.sv
/*
 * tb_sfcfe_top: self-checking bench for the front end with a host model.
 * Assumes the array side is played by the bench through its ports.
 */
`timescale 1ns/1ps
module tb_sfcfe_top;
    import sfcfe_pkg::*;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic cs_n, sclk, mosi, hold_n, miso_o, miso_oe, act_stb, act_data_stb;
    logic write_permit_latch, sleep_o, oe_any;
    logic array_busy = 1'b0;
    logic [7:0] array_rdata = 8'h00;
    logic [3:0] act_o, a_act;
    logic [23:0] act_addr, a_addr;
    logic [7:0] act_data, status_o, a_data, b, c;
    logic [7:0] r[$];
    int n_mismatch = 0;
    int n_checks = 0;
    int n_act = 0;
    int cyc = 0;

    sfcfe_top DUT (.clk(clk), .nrst(nrst), .cs_n(cs_n), .sclk(sclk), .mosi(mosi),
        .hold_n(hold_n), .miso_o(miso_o), .miso_oe(miso_oe), .array_busy(array_busy),
        .array_rdata(array_rdata), .act_o(act_o), .act_stb(act_stb),
        .act_addr(act_addr), .act_data(act_data), .act_data_stb(act_data_stb),
        .status_o(status_o), .write_permit_latch(write_permit_latch), .sleep_o(sleep_o));
    sfcfe_host host (.clk(clk), .cs_n(cs_n), .sclk(sclk), .mosi(mosi),
        .hold_n(hold_n), .miso_o(miso_o), .miso_oe(miso_oe));

    initial begin
        forever #5 clk = ~clk;
    end
    // one-cycle pulses caught mid-cycle, away from the launching edge
    always @(negedge clk) begin
        if (act_stb === 1'b1) begin
            n_act <= n_act + 1;
            a_act <= act_o;
            a_addr <= act_addr;
        end
        if (act_data_stb === 1'b1) begin
            a_data <= act_data;
        end
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            n_mismatch++;
            conclude();
        end
    end

    task automatic conclude();
        if (n_mismatch == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : conclude

    task automatic chk(input logic ok, input string m);
        n_checks++;
        if (ok !== 1'b1) begin
            n_mismatch++;
            $display("Error %0t: %s", $time, m);
        end
    endtask : chk

    task automatic xfer(input logic [7:0] q[$]);
        logic o;
        r.delete();
        oe_any = 1'b0;
        host.sel(1'b0);
        foreach (q[i]) begin
            host.bits(q[i], 8, b, o);
            r.push_back(b);
            if (i > 0) oe_any = oe_any | o;
        end
        host.sel(1'b1);
    endtask : xfer

    task automatic t_latch();
        xfer('{OP_LATCH_SET});
        chk(write_permit_latch === 1'b1 && a_act === SF_ACT_LATCH_SET, "latch set");
        xfer('{OP_LATCH_CLEAR});
        chk(write_permit_latch === 1'b0 && a_act === SF_ACT_LATCH_CLEAR, "latch clr");
    endtask : t_latch

    task automatic t_ident();
        xfer('{OP_IDENT_READ, 8'h00, 8'h00, 8'h00});
        chk(r[1] === MAKER_CODE && r[2] === PART_TYPE && r[3] === PART_CODE, "ident");
        foreach (r[i]) c = r[i];
        xfer('{OP_MAKER_PART, 8'h00, 8'h00, SEL_MAKER_FIRST, 8'h00, 8'h00});
        chk(r[4] === MAKER_CODE, "maker first");
        xfer('{OP_MAKER_PART, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00});
        chk(r[5] === MAKER_CODE && r[4] !== MAKER_CODE, "part first");
    endtask : t_ident

    task automatic t_status();
        xfer('{OP_LATCH_SET});
        xfer('{OP_STATUS_STORE, 8'hA8});
        chk(status_o[7:2] === 6'h2A && write_permit_latch === 1'b0, "status store");
        @(posedge clk) array_busy <= 1'b1;
        xfer('{OP_STATUS_FETCH, 8'h00});
        chk(r[1] === 8'hA9 && oe_any === 1'b1, "status fetch");
    endtask : t_status

    task automatic t_read();
        @(posedge clk) array_rdata <= 8'h96;
        xfer('{OP_READ, 8'h01, 8'h23, 8'h45, 8'h00});
        chk(r[4] === 8'h96, "read");
        xfer('{OP_FAST_READ, 8'h01, 8'h23, 8'h45, 8'hFF, 8'h00});
        chk(r[5] === 8'h96, "fast read");
    endtask : t_read

    task automatic t_wipe();
        logic [7:0] ops[6] = '{OP_SECTOR_WIPE, OP_BLOCK_WIPE_A, OP_BLOCK_WIPE_B,
            OP_CHIP_WIPE_A, OP_CHIP_WIPE_B, OP_PAGE_WRITE};
        sfcfe_act_t acts[6] = '{SF_ACT_SECTOR_WIPE, SF_ACT_BLOCK_WIPE, SF_ACT_BLOCK_WIPE,
            SF_ACT_CHIP_WIPE, SF_ACT_CHIP_WIPE, SF_ACT_PAGE_WRITE};
        for (int i = 0; i < 6; i++) begin
            xfer('{OP_LATCH_SET});
            if (i == 3 || i == 4) xfer('{ops[i]});
            else if (i == 5) xfer('{ops[i], 8'hE5, 8'hA1, 8'h23, 8'h3C});
            else xfer('{ops[i], 8'hE5, 8'hA1, 8'h23});
            chk(a_act === acts[i] && write_permit_latch === 1'b0, "wipe action");
            if (i != 3 && i != 4) chk(a_addr[23:16] === 8'h05, "block field");
            if (i == 0 || i == 5) chk(a_addr[15:12] === 4'hA, "sector field");
        end
        chk(a_data === 8'h3C, "page data");
    endtask : t_wipe

    task automatic t_sleep();
        xfer('{OP_SLEEP_ENTER});
        chk(sleep_o === 1'b1, "sleep");
        xfer('{OP_SLEEP_EXIT});
        chk(sleep_o === 1'b0, "wake");
        xfer('{OP_SLEEP_EXIT, 8'h00, 8'h00, 8'h00, 8'h00});
        chk(r[4] === SIGNATURE, "signature");
    endtask : t_sleep

    task automatic t_refuse();
        int n0;
        logic o;
        n0 = n_act;
        host.sel(1'b0);
        host.bits(OP_LATCH_SET, 7, b, o);
        host.sel(1'b1);
        chk(write_permit_latch === 1'b0 && n_act == n0, "partial byte");
        xfer('{8'hFF, 8'h00, 8'h00});
        chk(oe_any === 1'b0, "unknown opcode");
    endtask : t_refuse

    task automatic t_pause();
        logic o;
        logic [7:0] hi;
        host.sel(1'b0);
        host.bits(OP_STATUS_FETCH, 8, b, o);
        host.bits(8'h00, 4, hi, o);
        host.pause(1'b0);
        @(posedge clk) array_busy <= 1'b0;
        host.bits(8'hFF, 3, b, o);
        chk(o === 1'b0 && status_o[0] === 1'b0, "paused");
        @(posedge clk) array_busy <= 1'b1;
        host.pause(1'b1);
        host.bits(8'h00, 4, b, o);
        host.sel(1'b1);
        chk({hi[3:0], b[3:0]} === 8'hA9 && o === 1'b1, "byte across pause");
        host.sel(1'b0);
        host.bits(OP_LATCH_SET, 8, b, o);
        host.pause(1'b0);
        host.sel(1'b1);
        chk(write_permit_latch === 1'b0, "select rise in pause");
        host.pause(1'b1);
        xfer('{OP_LATCH_SET});
        chk(write_permit_latch === 1'b1, "resume");
        xfer('{OP_LATCH_CLEAR});
    endtask : t_pause

    initial begin
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        repeat (4) @(posedge clk);
        chk(write_permit_latch === 1'b0 && miso_oe === 1'b0, "reset");
        t_latch();
        t_ident();
        t_status();
        t_read();
        t_wipe();
        t_sleep();
        t_refuse();
        t_pause();
        conclude();
    end
endmodule : tb_sfcfe_top
